/* File: include/amp_regs_pkg.sv */
// package for the amplifier monitor and clock fault register group
// assumes a 100 MHz core clock and byte-wide register port
package amp_regs_pkg;

  // core clock rate
  localparam real CLK_MHZ = 100.0;

  // register offsets on the register port
  localparam logic [6:0] INT_FLAGS_ADDR = 7'h26;
  localparam logic [6:0] TEMP_SENSE_ADDR = 7'h31;
  localparam logic [6:0] LOW_POWER_ADDR = 7'h35;
  localparam logic [6:0] RATE_SELECT_ADDR = 7'h36;
  localparam logic [6:0] FAULT_RECOVERY_ADDR = 7'h4f;
  localparam logic [6:0] FAULT_TIMING_ADDR = 7'h50;

  // reset values
  localparam logic [7:0] TEMP_SENSE_RST = 8'h00;
  localparam logic [7:0] LOW_POWER_RST = 8'h00;
  localparam logic [7:0] RATE_SELECT_RST = 8'h32;
  localparam logic [7:0] FAULT_RECOVERY_RST = 8'h00;
  localparam logic [7:0] FAULT_TIMING_RST = 8'h11;

  // field positions
  localparam int TEMP_REQ_BIT = 5;
  localparam int TEMP_VALID_BIT = 4;
  localparam int TEMP_CODE_LSB = 0;
  localparam int POR_PD_BIT = 7;
  localparam int RATE_LSB = 0;
  localparam int FAULT2_NO_RETRY_BIT = 3;
  localparam int FAULT1_NO_RETRY_BIT = 2;
  localparam int RAMP_RATE_LSB = 6;
  localparam int FAULT1_TIMEOUT_LSB = 3;
  localparam int FAULT2_TIMEOUT_LSB = 0;
  localparam int FAULT1_STICKY_BIT = 5;
  localparam int FAULT2_STICKY_BIT = 2;

  // sample rate encodings
  typedef enum logic [1:0] {
    RATE_8K = 2'h0,
    RATE_16K = 2'h1,
    RATE_48K = 2'h2,
    RATE_96K = 2'h3
  } rate_sel_t;

  // gain ramp-down rates, microseconds per dB
  localparam real RAMP0_US = 15.0;
  localparam real RAMP1_US = 30.0;
  localparam real RAMP2_US = 60.0;
  localparam real RAMP3_US = 120.0;
  localparam logic [13:0] RAMP0_CYC = 14'(int'(RAMP0_US * CLK_MHZ));
  localparam logic [13:0] RAMP1_CYC = 14'(int'(RAMP1_US * CLK_MHZ));
  localparam logic [13:0] RAMP2_CYC = 14'(int'(RAMP2_US * CLK_MHZ));
  localparam logic [13:0] RAMP3_CYC = 14'(int'(RAMP3_US * CLK_MHZ));

  // missing-clock timeouts
  localparam real TO0_US = 10.6;
  localparam real TO1_US = 21.3;
  localparam real TO2_US = 42.6;
  localparam real TO3_US = 85.3;
  localparam real TO4_MS = 0.34;
  localparam real TO5_MS = 0.68;
  localparam real TO6_MS = 1.36;
  localparam real TO7_MS = 2.73;
  localparam logic [19:0] TO0_CYC = 20'(int'(TO0_US * CLK_MHZ));
  localparam logic [19:0] TO1_CYC = 20'(int'(TO1_US * CLK_MHZ));
  localparam logic [19:0] TO2_CYC = 20'(int'(TO2_US * CLK_MHZ));
  localparam logic [19:0] TO3_CYC = 20'(int'(TO3_US * CLK_MHZ));
  localparam logic [19:0] TO4_CYC = 20'(int'(TO4_MS * 1000.0 * CLK_MHZ));
  localparam logic [19:0] TO5_CYC = 20'(int'(TO5_MS * 1000.0 * CLK_MHZ));
  localparam logic [19:0] TO6_CYC = 20'(int'(TO6_MS * 1000.0 * CLK_MHZ));
  localparam logic [19:0] TO7_CYC = 20'(int'(TO7_MS * 1000.0 * CLK_MHZ));

  // one register port access
  typedef struct packed {
    logic [6:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  // temperature sensor handshake inputs
  typedef struct packed {
    logic done;
    logic [3:0] code;
  } temp_result_t;

endpackage : amp_regs_pkg

/* File: rtl/clock_loss_timer.sv */
// missing-clock detector: flags loss when the sensed clock stops toggling
// assumes the sensed clock level is already synchronous to the core clock
`timescale 1ns/1ps
module clock_loss_timer
  import amp_regs_pkg::*;
(
  // core clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // sensed clock level and timeout limit in core cycles
  input wire logic sense_in,
  input wire logic [19:0] limit_in,
  // loss indication, a level
  output logic lost_out
);

  typedef struct packed {
    logic sense_prev;
    logic [19:0] count;
    logic lost;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  // restart the count on every edge of the sensed clock
  always_comb
  begin
    s_d = s_q;
    s_d.sense_prev = sense_in;
    if (sense_in != s_q.sense_prev)
    begin
      s_d.count = 20'h0_0000;
      s_d.lost = 1'b0;
    end
    else if (s_q.count >= limit_in - 20'h0_0001)
    begin
      s_d.lost = 1'b1;
    end
    else
    begin
      s_d.count = s_q.count + 20'h0_0001;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign lost_out = s_q.lost;

endmodule : clock_loss_timer

/* File: rtl/amp_monitor_clock_fault_regs.sv */
// control and status registers for die temperature, low power, sample rate
// and clock fault handling of the amplifier
// assumes a byte-wide register port already decoded from the serial host port
//
// Notes on behaviour
// - writing one to temp_request starts a reading; it self-clears on completion.
// - temp_reading_valid reads zero during acquisition, one after a completed one.
// - temp_range_code is a 4-bit band, 0 below 30 C, 15 above 140 C.
// - low power bit 7 one powers the battery reset monitor down.
// - 2-bit rate field selects 8, 16, 48 or 96 kHz.
// - detector 2 fault recovers alone when its no-retry bit is zero, else latches.
// - detector 1 fault recovers alone when its no-retry bit is zero, else latches.
// - on clock fault gain ramps down at 15, 30, 60 or 120 us per dB.
// - each detector mutes playback after its selected missing-clock timeout.
// - separate sticky flags per detector stay set until software reads them.
`timescale 1ns/1ps
module amp_monitor_clock_fault_regs
  import amp_regs_pkg::*;
#(
  parameter logic [7:0][19:0] TIMEOUT_CYC = {TO7_CYC, TO6_CYC, TO5_CYC, TO4_CYC,
                                             TO3_CYC, TO2_CYC, TO1_CYC, TO0_CYC},
  parameter logic [3:0][13:0] RAMP_CYC = {RAMP3_CYC, RAMP2_CYC, RAMP1_CYC, RAMP0_CYC}
)
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // register port
  input wire reg_req_t REG_REQ_IN,
  output logic [7:0] REG_RDATA_OUT,
  // temperature sensor
  input wire temp_result_t TEMP_RESULT_IN,
  output logic TEMP_START_OUT,
  // sensed clocks, bit 0 detector 1, bit 1 detector 2
  input wire logic [1:0] CLK_SENSE_IN,
  // controls to the audio path
  output logic POR_MONITOR_PD_OUT,
  output logic [1:0] SAMPLE_RATE_OUT,
  output logic PLAYBACK_MUTE_OUT,
  output logic CLOCK_SHUTDOWN_OUT,
  output logic GAIN_STEP_OUT
);

  typedef struct packed {
    logic [1:0] temp_rsvd;
    logic temp_req;
    logic temp_valid;
    logic [3:0] temp_code;
    logic temp_start;
    logic [7:0] low_power;
    logic [7:0] rate_select;
    logic [7:0] fault_recovery;
    logic [7:0] fault_timing;
    logic [1:0] sticky;
    logic [1:0] lost_prev;
    logic [1:0] shut;
    logic [13:0] ramp_cnt;
    logic ramp_step;
    logic [7:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] lost;
  logic [1:0] no_retry;
  logic [1:0] lost_rise;
  logic wr_hit_rec;
  logic muting;

  // timeout lookup for a 3-bit field
  function automatic logic [19:0] timeout_sel(input logic [2:0] code);
    timeout_sel = TIMEOUT_CYC[code];
  endfunction : timeout_sel

  // read data mux over the mapped registers
  function automatic logic [7:0] read_mux(input state_t s, input logic [6:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      INT_FLAGS_ADDR:
      begin
        v[FAULT1_STICKY_BIT] = s.sticky[0];
        v[FAULT2_STICKY_BIT] = s.sticky[1];
      end
      TEMP_SENSE_ADDR:
      begin
        v = {s.temp_rsvd, s.temp_req, s.temp_valid, s.temp_code};
      end
      LOW_POWER_ADDR: v = s.low_power;
      RATE_SELECT_ADDR: v = s.rate_select;
      FAULT_RECOVERY_ADDR: v = s.fault_recovery;
      FAULT_TIMING_ADDR: v = s.fault_timing;
      default: v = 8'h00;
    endcase
    read_mux = v;
  endfunction : read_mux

  // the two missing-clock detectors
  clock_loss_timer u_detect1 (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .sense_in(CLK_SENSE_IN[0]),
    .limit_in(timeout_sel(s_q.fault_timing[FAULT1_TIMEOUT_LSB +: 3])),
    .lost_out(lost[0])
  );

  clock_loss_timer u_detect2 (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .sense_in(CLK_SENSE_IN[1]),
    .limit_in(timeout_sel(s_q.fault_timing[FAULT2_TIMEOUT_LSB +: 3])),
    .lost_out(lost[1])
  );

  // fault decode helpers
  assign no_retry[0] = s_q.fault_recovery[FAULT1_NO_RETRY_BIT];
  assign no_retry[1] = s_q.fault_recovery[FAULT2_NO_RETRY_BIT];
  assign lost_rise = lost & ~s_q.lost_prev;
  assign wr_hit_rec = REG_REQ_IN.wr && (REG_REQ_IN.addr == FAULT_RECOVERY_ADDR);
  assign muting = |lost || |s_q.shut;

  // next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.temp_start = 1'b0;
    s_d.ramp_step = 1'b0;
    s_d.lost_prev = lost;

    // plain writes
    if (REG_REQ_IN.wr)
    begin
      case (REG_REQ_IN.addr)
        TEMP_SENSE_ADDR: s_d.temp_rsvd = REG_REQ_IN.wdata[7:6];
        LOW_POWER_ADDR: s_d.low_power = REG_REQ_IN.wdata;
        RATE_SELECT_ADDR: s_d.rate_select = REG_REQ_IN.wdata;
        FAULT_RECOVERY_ADDR: s_d.fault_recovery = REG_REQ_IN.wdata;
        FAULT_TIMING_ADDR: s_d.fault_timing = REG_REQ_IN.wdata;
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    // start a temperature reading; a request while busy is ignored
    if (REG_REQ_IN.wr && REG_REQ_IN.addr == TEMP_SENSE_ADDR &&
        REG_REQ_IN.wdata[TEMP_REQ_BIT] && !s_q.temp_req)
    begin
      s_d.temp_req = 1'b1;
      s_d.temp_valid = 1'b0;
      s_d.temp_start = 1'b1;
    end

    // completion stores the code and self-clears the request
    if (s_q.temp_req && TEMP_RESULT_IN.done)
    begin
      s_d.temp_code = TEMP_RESULT_IN.code;
      s_d.temp_req = 1'b0;
      s_d.temp_valid = 1'b1;
    end
    // otherwise the code is left alone

    // sticky flags: reading clears, a new fault in the same cycle wins
    if (REG_REQ_IN.rd && REG_REQ_IN.addr == INT_FLAGS_ADDR)
      s_d.sticky = 2'b00;
    s_d.sticky = s_d.sticky | lost_rise;

    // latched shutdown: a write to the recovery register releases it
    if (wr_hit_rec)
      s_d.shut = 2'b00;
    if (lost[0] && no_retry[0])
      s_d.shut[0] = 1'b1;
    if (lost[1] && no_retry[1])
      s_d.shut[1] = 1'b1;

    // gain ramp-down pacing while muting
    if (muting)
    begin
      if (s_q.ramp_cnt >= RAMP_CYC[s_q.fault_timing[RAMP_RATE_LSB +: 2]] - 14'h0001)
      begin
        s_d.ramp_cnt = 14'h0000;
        s_d.ramp_step = 1'b1;
      end
      else
      begin
        s_d.ramp_cnt = s_q.ramp_cnt + 14'h0001;
      end
    end
    else
    begin
      s_d.ramp_cnt = 14'h0000;
    end

    // registered read data
    if (REG_REQ_IN.rd)
      s_d.rdata = read_mux(s_q, REG_REQ_IN.addr);
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      s_q <= '0;
      s_q.temp_rsvd <= TEMP_SENSE_RST[7:6];
      s_q.low_power <= LOW_POWER_RST;
      s_q.rate_select <= RATE_SELECT_RST;
      s_q.fault_recovery <= FAULT_RECOVERY_RST;
      s_q.fault_timing <= FAULT_TIMING_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign REG_RDATA_OUT = s_q.rdata;
  assign TEMP_START_OUT = s_q.temp_start;
  assign POR_MONITOR_PD_OUT = s_q.low_power[POR_PD_BIT];
  assign SAMPLE_RATE_OUT = s_q.rate_select[RATE_LSB +: 2];
  // mute while a clock is missing, or while a latched shutdown stands
  assign PLAYBACK_MUTE_OUT = muting;
  assign CLOCK_SHUTDOWN_OUT = |s_q.shut;
  assign GAIN_STEP_OUT = s_q.ramp_step;

endmodule : amp_monitor_clock_fault_regs

/* File: test/amp_regs_asserts.sv */
// port checker for the amplifier register group
// assumes the top module ports and short simulation counts
`timescale 1ns/1ps
module amp_regs_asserts
  import amp_regs_pkg::*;
#(
  parameter logic [7:0][19:0] TIMEOUT_CYC = '0,
  parameter logic [3:0][13:0] RAMP_CYC = '0
)
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // register port and sensor
  input wire reg_req_t REG_REQ_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire temp_result_t TEMP_RESULT_IN,
  input wire logic TEMP_START_OUT,
  // clocks and audio controls
  input wire logic [1:0] CLK_SENSE_IN,
  input wire logic POR_MONITOR_PD_OUT,
  input wire logic [1:0] SAMPLE_RATE_OUT,
  input wire logic PLAYBACK_MUTE_OUT,
  input wire logic CLOCK_SHUTDOWN_OUT,
  input wire logic GAIN_STEP_OUT
);
  logic [1:0][19:0] quiet_q;
  logic [1:0] prev_q;
  logic wr_lp, wr_rate, wr_rec;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // write strobes per register
  assign wr_lp = REG_REQ_IN.wr && REG_REQ_IN.addr == LOW_POWER_ADDR;
  assign wr_rate = REG_REQ_IN.wr && REG_REQ_IN.addr == RATE_SELECT_ADDR;
  assign wr_rec = REG_REQ_IN.wr && REG_REQ_IN.addr == FAULT_RECOVERY_ADDR;
  // edges since each sensed clock last changed
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      quiet_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      prev_q <= CLK_SENSE_IN;
      for (int i = 0; i < 2; i++)
        quiet_q[i] <= (CLK_SENSE_IN[i] != prev_q[i]) ? 20'h0 : quiet_q[i] + 20'h1;
    end
  sequence one_pulse;
    GAIN_STEP_OUT ##1 !GAIN_STEP_OUT;
  endsequence
  temp_start_a: assert property (TEMP_START_OUT |-> $past(REG_REQ_IN.wr) &&
    $past(REG_REQ_IN.addr) == TEMP_SENSE_ADDR && $past(REG_REQ_IN.wdata[TEMP_REQ_BIT]))
    else $error("start without request write");
  rdata_hold_a: assert property (!$stable(REG_RDATA_OUT) |-> $past(REG_REQ_IN.rd))
    else $error("read data moved without read");
  por_change_a: assert property (!$stable(POR_MONITOR_PD_OUT) |-> $past(wr_lp) ||
    $past(wr_lp, 2)) else $error("monitor control moved without write");
  rate_change_a: assert property (!$stable(SAMPLE_RATE_OUT) |-> $past(wr_rate) ||
    $past(wr_rate, 2)) else $error("rate moved without write");
  mute_cause_a: assert property ($rose(PLAYBACK_MUTE_OUT) |->
    quiet_q[0] >= TIMEOUT_CYC[0] - 20'h1 || quiet_q[1] >= TIMEOUT_CYC[0] - 20'h1)
    else $error("mute before timeout");
  shut_mute_a: assert property (CLOCK_SHUTDOWN_OUT |-> PLAYBACK_MUTE_OUT)
    else $error("shutdown without mute");
  shut_hold_a: assert property (CLOCK_SHUTDOWN_OUT && !wr_rec |=> CLOCK_SHUTDOWN_OUT)
    else $error("shutdown left without recovery write");
  step_pulse_a: assert property (GAIN_STEP_OUT |-> one_pulse)
    else $error("gain step longer than one cycle");
  step_cause_a: assert property (GAIN_STEP_OUT |-> $past(PLAYBACK_MUTE_OUT))
    else $error("gain step while not muting");
  shut_rise_a: assert property ($rose(CLOCK_SHUTDOWN_OUT) |-> $past(PLAYBACK_MUTE_OUT))
    else $error("shutdown latched without a lost clock");
  shut_release_a: assert property ($fell(CLOCK_SHUTDOWN_OUT) |-> $past(wr_rec))
    else $error("shutdown released without recovery write");
endmodule : amp_regs_asserts

bind amp_monitor_clock_fault_regs amp_regs_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .RAMP_CYC(RAMP_CYC)) chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .REG_REQ_IN(REG_REQ_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .TEMP_RESULT_IN(TEMP_RESULT_IN),
  .TEMP_START_OUT(TEMP_START_OUT), .CLK_SENSE_IN(CLK_SENSE_IN),
  .POR_MONITOR_PD_OUT(POR_MONITOR_PD_OUT), .SAMPLE_RATE_OUT(SAMPLE_RATE_OUT),
  .PLAYBACK_MUTE_OUT(PLAYBACK_MUTE_OUT), .CLOCK_SHUTDOWN_OUT(CLOCK_SHUTDOWN_OUT),
  .GAIN_STEP_OUT(GAIN_STEP_OUT));

/* File: test/amp_monitor_clock_fault_regs_tb.sv */
// self-checking bench for the amplifier register group
// assumes short timeout and ramp counts given at the instance
`timescale 1ns/1ps
module amp_monitor_clock_fault_regs_tb
  import amp_regs_pkg::*;
;
  logic clk = 0, rst_n = 0, por, mute, shut, step, tstart;
  logic [1:0] sense = 0, tog = 2'h3, rate;
  logic [7:0] rdata;
  reg_req_t req = '0;
  temp_result_t tres = '0;
  int n_fail = 0, tests_run = 0, cyc = 0, n_start = 0, n;
  // clock, sensed clocks and start counter
  always #5 clk = ~clk;
  always @(negedge clk) sense <= sense ^ tog;
  always @(negedge clk) n_start += (tstart === 1'b1); // sampled mid-cycle, away from launch
  amp_monitor_clock_fault_regs #(
    .TIMEOUT_CYC({20'h50, 20'h46, 20'h3c, 20'h32, 20'h28, 20'h1e, 20'h14, 20'ha}),
    .RAMP_CYC({14'h10, 14'h8, 14'h4, 14'h2})
  ) dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
    .TEMP_RESULT_IN(tres), .TEMP_START_OUT(tstart), .CLK_SENSE_IN(sense),
    .POR_MONITOR_PD_OUT(por), .SAMPLE_RATE_OUT(rate), .PLAYBACK_MUTE_OUT(mute),
    .CLOCK_SHUTDOWN_OUT(shut), .GAIN_STEP_OUT(step));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h0};
    @(negedge clk);
    req.rd = 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd
  task automatic done(input logic [3:0] c);
    tres = '{done: 1'b1, code: c};
    @(negedge clk);
    tres.done = 1'b0;
  endtask : done
  task automatic wait_mute(input logic v);
    n = 0;
    while (mute !== v && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_mute
  task automatic wait_step();
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (step !== 1'b1 && n < 100);
  endtask : wait_step
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  // main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    rd(TEMP_SENSE_ADDR, TEMP_SENSE_RST);
    rd(LOW_POWER_ADDR, LOW_POWER_RST);
    rd(RATE_SELECT_ADDR, RATE_SELECT_RST);
    rd(FAULT_RECOVERY_ADDR, FAULT_RECOVERY_RST);
    rd(FAULT_TIMING_ADDR, FAULT_TIMING_RST);
    rd(INT_FLAGS_ADDR, 8'h0);
    wr(7'h7f, 8'hff);
    rd(7'h7f, 8'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(RATE_SELECT_ADDR, 8'(i));
      chk({6'h0, rate}, 8'(i));
    end
    wr(LOW_POWER_ADDR, 8'h80);
    chk({7'h0, por}, 8'h1);
    rd(LOW_POWER_ADDR, 8'h80);
    // temperature request, refused restart, held code
    wr(TEMP_SENSE_ADDR, 8'h20);
    rd(TEMP_SENSE_ADDR, 8'h20);
    wr(TEMP_SENSE_ADDR, 8'h20);
    done(4'hf);
    rd(TEMP_SENSE_ADDR, 8'h1f);
    wr(TEMP_SENSE_ADDR, 8'h20);
    rd(TEMP_SENSE_ADDR, 8'h2f);
    done(4'h0);
    rd(TEMP_SENSE_ADDR, 8'h10);
    chk(8'(n_start), 8'h2);
    // detector 1 loss with automatic recovery
    wr(FAULT_TIMING_ADDR, 8'h40);
    tog = 2'h2;
    wait_mute(1'b1);
    chk(8'(n >= 9 && n <= 13), 8'h1);
    wait_step();
    wait_step();
    chk(8'(n), 8'h4);
    chk({7'h0, shut}, 8'h0);
    tog = 2'h3;
    wait_mute(1'b0);
    chk(8'(n < 4), 8'h1);
    rd(INT_FLAGS_ADDR, 8'h20);
    rd(INT_FLAGS_ADDR, 8'h0);
    // detector 2 loss latched until software recovery
    wr(FAULT_TIMING_ADDR, 8'h3);
    wr(FAULT_RECOVERY_ADDR, 8'h8);
    tog = 2'h1;
    wait_mute(1'b1);
    chk(8'(n >= 39 && n <= 43), 8'h1);
    wait_step();
    wait_step();
    chk(8'(n), 8'h2);
    tog = 2'h3;
    repeat (5) @(negedge clk);
    chk({6'h0, mute, shut}, 8'h3);
    wr(FAULT_RECOVERY_ADDR, 8'h8);
    chk({6'h0, mute, shut}, 8'h0);
    rd(INT_FLAGS_ADDR, 8'h4);
    // slow ramp codes and long timeouts on detector 1, latched on the last pass
    for (int r = 2; r < 4; r++)
    begin
      wr(FAULT_RECOVERY_ADDR, (r == 3) ? 8'h04 : 8'h00);
      wr(FAULT_TIMING_ADDR, 8'((r << 6) | ((r + 4) << 3)));
      tog = 2'h2;
      wait_mute(1'b1);
      chk(8'(n >= 10 * (r + 5) - 1 && n <= 10 * (r + 5) + 3), 8'h1);
      wait_step();
      wait_step();
      chk(8'(n), 8'(2 << r));
      tog = 2'h3;
      repeat (5) @(negedge clk);
      chk({6'h0, mute, shut}, (r == 3) ? 8'h03 : 8'h00);
      wr(FAULT_RECOVERY_ADDR, 8'h00);
      chk({6'h0, mute, shut}, 8'h00);
      rd(INT_FLAGS_ADDR, 8'h20);
    end
    give_verdict();
  end
endmodule : amp_monitor_clock_fault_regs_tb
